// file: include/tcc_consts.vh
// Purpose: constants of the timer capture channel
// Assumes: 32-bit register port, byte offsets
// Notes: included by the channel and its prescaler
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH
`define TCC_A_PINLVL 8'h3c
`define TCC_A_ODEN 8'h40
`define TCC_A_ODDIS 8'h44
`define TCC_A_ODSTAT 8'h48
`define TCC_A_CGEN 8'h50
`define TCC_A_CGDIS 8'h54
`define TCC_A_CGSTAT 8'h58
`define TCC_A_CTRL 8'h60
`define TCC_A_MODE 8'h64
`define TCC_A_STAT 8'h70
`define TCC_A_IEN 8'h74
`define TCC_A_IDIS 8'h78
`define TCC_A_IMASK 8'h7c
`define TCC_A_CNT 8'h80
`define TCC_A_CAPA 8'h84
`define TCC_A_CAPB 8'h88
`define TCC_A_CMPC 8'h8c
`define TCC_PIN_LSB 16
`define TCC_CTL_RST 0
`define TCC_CTL_ON 1
`define TCC_CTL_OFF 2
`define TCC_CTL_TRG 3
`define TCC_CG_PIO 0
`define TCC_CG_TMR 1
`define TCC_MODE_MASK 20'hfc7ff
`define TCC_MODE_RESET 20'h00000
`define TCC_CG_RESET 2'h0
`define TCC_M_CLOCK_SELECT 2:0
`define TCC_M_INV 3
`define TCC_M_BURST 5:4
`define TCC_M_STOPB 6
`define TCC_M_OFFB 7
`define TCC_M_TEDGE 9:8
`define TCC_M_TPIN 10
`define TCC_M_CTRG 14
`define TCC_M_WAVE 15
`define TCC_M_LDA 17:16
`define TCC_M_LDB 19:18
`define TCC_S_COVF 0
`define TCC_S_LOVR 1
`define TCC_S_CPC 4
`define TCC_S_LDA 5
`define TCC_S_LDB 6
`define TCC_S_ETRG 7
`define TCC_S_CLKSTA 8
`define TCC_S_MIOA 9
`define TCC_S_MIOB 10
`define TCC_FLAG_MASK 19'h700f3
`define TCC_DIV_BITS 10
`endif

// file: design/tcc_clk_div.v
// Purpose: core clock prescaler for the capture channel
// Assumes: run is the channel clock gate
// Notes: tick[k] pulses once per 2,8,32,128,1024 core clocks
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
module tcc_clk_div (
  input wire clk_sys,
  input wire rstn,
  input wire clr,
  input wire run,
  output wire [4:0] tick
);
  reg [`TCC_DIV_BITS-1:0] div_ff;
  wire [`TCC_DIV_BITS-1:0] nxt_div;

  assign nxt_div = div_ff + {{(`TCC_DIV_BITS-1){1'b0}}, 1'b1};

  always @(posedge clk_sys) begin
    if (!rstn || clr) begin
      div_ff <= {`TCC_DIV_BITS{1'b0}};
    end else if (run) begin
      div_ff <= nxt_div;
    end
  end

  assign tick[0] = run & div_ff[0];
  assign tick[1] = run & (&div_ff[2:0]);
  assign tick[2] = run & (&div_ff[4:0]);
  assign tick[3] = run & (&div_ff[6:0]);
  assign tick[4] = run & (&div_ff[9:0]);
endmodule // tcc_clk_div
`default_nettype wire

// file: design/tcc_channel.v
// Purpose: one 16-bit timer channel in capture mode with pin and clock gate control
// Assumes: all inputs synchronous to clk_sys; slave never stalls
// Notes: read data appear the cycle after the read strobe
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
module tcc_channel (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata_ff,
  output reg irq_ff,
  input wire timer_io_a_in,
  output reg timer_io_a_out_ff,
  output reg timer_io_a_oe_ff,
  input wire timer_io_b_in,
  output reg timer_io_b_out_ff,
  output reg timer_io_b_oe_ff,
  input wire ext_count_clock_pin,
  input wire [2:0] external_clock,
  input wire sync_trigger
);
  function edge_hit;
    input [1:0] sel;
    input prv;
    input cur;
    begin
      edge_hit = (sel[0] & ~prv & cur) | (sel[1] & prv & ~cur);
    end
  endfunction

  function upd_flag;
    input cur;
    input clr;
    input set;
    begin
      upd_flag = (cur & ~clr) | set; // set beats the read clear
    end
  endfunction

  reg [1:0] cgate_ff;
  reg [2:0] pin_lvl_ff;
  reg [2:0] od_ff;
  reg [19:0] mode_ff;
  reg [15:0] cnt_ff;
  reg [15:0] cap_a_ff;
  reg [15:0] cap_b_ff;
  reg [15:0] cmp_c_ff;
  reg clk_on_ff;
  reg run_ff;
  reg trig_pend_ff;
  reg a_unread_ff;
  reg b_unread_ff;
  reg prv_a_ff;
  reg prv_b_ff;
  reg prv_t_ff;
  reg prv_src_ff;
  reg [18:0] flags_ff;
  reg [18:0] imask_ff;
  reg [31:0] nxt_rdata;
  reg [18:0] nxt_flags;
  reg [15:0] nxt_cnt;
  reg src_lvl;
  reg burst_ok;
  reg cnt_tick;

  wire wr_ctrl;
  wire soft_rst;
  wire lrst;
  wire tmr_on;
  wire pio_on;
  wire capture_mode;
  wire [4:0] div_tick;
  wire trig_pin_prv;
  wire trig_pin_cur;
  wire ext_trig;
  wire load_a;
  wire load_b;
  wire stop_b;
  wire off_b;
  wire sw_trig;
  wire any_trig;
  wire wrap;
  wire cmp_hit;
  wire rd_stat;
  wire [2:0] pin_now;
  wire [2:0] pin_chg;

  assign wr_ctrl = wr_stb && (addr == `TCC_A_CTRL);
  assign soft_rst = wr_ctrl && wdata[`TCC_CTL_RST];
  assign lrst = !rstn || soft_rst;
  assign tmr_on = cgate_ff[`TCC_CG_TMR];
  assign pio_on = cgate_ff[`TCC_CG_PIO];
  assign capture_mode = ~mode_ff[`TCC_M_WAVE];
  assign rd_stat = rd_stb && (addr == `TCC_A_STAT);
  assign pin_now = {ext_count_clock_pin, timer_io_a_in, timer_io_b_in};

  tcc_clk_div u_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clr(soft_rst),
    .run(tmr_on),
    .tick(div_tick)
  );

  // counter clock source, invert and burst gate
  always @* begin
    case (mode_ff[`TCC_M_CLOCK_SELECT])
      3'h5: src_lvl = external_clock[0];
      3'h6: src_lvl = external_clock[1];
      3'h7: src_lvl = external_clock[2];
      default: src_lvl = 1'b0;
    endcase
    case (mode_ff[`TCC_M_BURST])
      2'h1: burst_ok = external_clock[0];
      2'h2: burst_ok = external_clock[1];
      2'h3: burst_ok = external_clock[2];
      default: burst_ok = 1'b1;
    endcase
    if (mode_ff[2]) begin
      // external sources count on the sampled edge chosen by the invert bit
      cnt_tick = mode_ff[`TCC_M_INV] ? (prv_src_ff & ~src_lvl) : (~prv_src_ff & src_lvl);
    end else begin
      cnt_tick = div_tick[mode_ff[1:0]];
    end
    if (mode_ff[`TCC_M_CLOCK_SELECT] == 3'h4) begin
      cnt_tick = div_tick[4];
    end
    cnt_tick = cnt_tick & burst_ok & tmr_on & clk_on_ff & capture_mode;
  end

  // io a and io b event decode
  assign trig_pin_prv = mode_ff[`TCC_M_TPIN] ? prv_a_ff : prv_b_ff;
  assign trig_pin_cur = mode_ff[`TCC_M_TPIN] ? timer_io_a_in : timer_io_b_in;
  assign ext_trig = tmr_on && capture_mode && clk_on_ff &&
    edge_hit(mode_ff[`TCC_M_TEDGE], trig_pin_prv, trig_pin_cur);
  assign load_a = tmr_on && capture_mode &&
    edge_hit(mode_ff[`TCC_M_LDA], prv_a_ff, timer_io_a_in);
  assign load_b = tmr_on && capture_mode &&
    edge_hit(mode_ff[`TCC_M_LDB], prv_a_ff, timer_io_a_in);
  assign stop_b = load_b && (mode_ff[`TCC_M_STOPB] || mode_ff[`TCC_M_OFFB]);
  assign off_b = load_b && mode_ff[`TCC_M_OFFB];
  assign sw_trig = (wr_ctrl && wdata[`TCC_CTL_TRG]) || sync_trigger;
  assign wrap = cnt_tick && run_ff && !trig_pend_ff && (cnt_ff == 16'hffff);
  assign cmp_hit = cnt_tick && (nxt_cnt == cmp_c_ff) && (nxt_cnt != cnt_ff);
  // a trigger raised by the same edge that stops on b load is dropped
  assign any_trig = (ext_trig || sw_trig || (cmp_hit && mode_ff[`TCC_M_CTRG])) && !stop_b;
  assign pin_chg = pin_now ^ {prv_t_ff, prv_a_ff, prv_b_ff};

  always @* begin
    if (trig_pend_ff) begin
      nxt_cnt = 16'h0000;
    end else if (run_ff) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // clock gate state survives the channel soft reset
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cgate_ff <= `TCC_CG_RESET;
    end else if (wr_stb && addr == `TCC_A_CGEN) begin
      cgate_ff <= cgate_ff | wdata[1:0];
    end else if (wr_stb && addr == `TCC_A_CGDIS) begin
      cgate_ff <= cgate_ff & ~wdata[1:0];
    end
  end

  // pin control registers
  always @(posedge clk_sys) begin
    if (lrst) begin
      od_ff <= 3'h0;
      pin_lvl_ff <= 3'h0;
      timer_io_a_out_ff <= 1'b0;
      timer_io_a_oe_ff <= 1'b0;
      timer_io_b_out_ff <= 1'b0;
      timer_io_b_oe_ff <= 1'b0;
    end else begin
      // capture mode only listens on the io pins
      timer_io_a_out_ff <= 1'b0;
      timer_io_a_oe_ff <= 1'b0;
      timer_io_b_out_ff <= 1'b0;
      timer_io_b_oe_ff <= 1'b0;
      if (pio_on) begin
        pin_lvl_ff <= pin_now;
      end
      if (wr_stb && addr == `TCC_A_ODEN) begin
        od_ff <= od_ff | wdata[`TCC_PIN_LSB+2:`TCC_PIN_LSB];
      end else if (wr_stb && addr == `TCC_A_ODDIS) begin
        od_ff <= od_ff & ~wdata[`TCC_PIN_LSB+2:`TCC_PIN_LSB];
      end
    end
  end

  // mode, compare, mask registers
  always @(posedge clk_sys) begin
    if (lrst) begin
      mode_ff <= `TCC_MODE_RESET;
      cmp_c_ff <= 16'h0000;
      imask_ff <= 19'h00000;
    end else if (wr_stb) begin
      if (addr == `TCC_A_MODE) begin
        mode_ff <= wdata[19:0] & `TCC_MODE_MASK;
      end
      if (addr == `TCC_A_CMPC) begin
        cmp_c_ff <= wdata[15:0];
      end
      if (addr == `TCC_A_IEN) begin
        imask_ff <= imask_ff | (wdata[18:0] & `TCC_FLAG_MASK);
      end
      if (addr == `TCC_A_IDIS) begin
        imask_ff <= imask_ff & ~wdata[18:0];
      end
    end
  end

  // counter clock enable, start and counting
  always @(posedge clk_sys) begin
    if (lrst) begin
      clk_on_ff <= 1'b0;
      run_ff <= 1'b0;
      trig_pend_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else begin
      if (wr_ctrl && wdata[`TCC_CTL_OFF]) begin
        clk_on_ff <= 1'b0;
      end else if (off_b) begin
        clk_on_ff <= 1'b0;
      end else if (wr_ctrl && wdata[`TCC_CTL_ON]) begin
        clk_on_ff <= 1'b1;
      end
      // a trigger waits for the next valid counter edge
      if (any_trig && clk_on_ff) begin
        trig_pend_ff <= 1'b1;
      end else if (cnt_tick || !clk_on_ff) begin
        trig_pend_ff <= 1'b0;
      end
      if (stop_b || (wr_ctrl && wdata[`TCC_CTL_OFF])) begin
        run_ff <= 1'b0;
      end else if (cnt_tick && trig_pend_ff) begin
        run_ff <= 1'b1;
      end
      if (cnt_tick) begin
        cnt_ff <= nxt_cnt;
      end
    end
  end

  // captures and unread tracking
  always @(posedge clk_sys) begin
    if (lrst) begin
      cap_a_ff <= 16'h0000;
      cap_b_ff <= 16'h0000;
      a_unread_ff <= 1'b0;
      b_unread_ff <= 1'b0;
    end else begin
      if (load_a) begin
        cap_a_ff <= cnt_ff;
      end
      if (load_b) begin
        cap_b_ff <= cnt_ff;
      end
      a_unread_ff <= load_a | (a_unread_ff & ~(rd_stb && addr == `TCC_A_CAPA));
      b_unread_ff <= load_b | (b_unread_ff & ~(rd_stb && addr == `TCC_A_CAPB));
    end
  end

  // edge history for pins and external source
  always @(posedge clk_sys) begin
    if (lrst) begin
      prv_a_ff <= 1'b0;
      prv_b_ff <= 1'b0;
      prv_t_ff <= 1'b0;
      prv_src_ff <= 1'b0;
    end else if (tmr_on) begin
      prv_a_ff <= timer_io_a_in;
      prv_b_ff <= timer_io_b_in;
      prv_t_ff <= ext_count_clock_pin;
      prv_src_ff <= src_lvl;
    end
  end

  // sticky status flags
  always @* begin
    nxt_flags = 19'h00000;
    nxt_flags[`TCC_S_COVF] = upd_flag(flags_ff[`TCC_S_COVF], rd_stat, wrap);
    nxt_flags[`TCC_S_LOVR] = upd_flag(flags_ff[`TCC_S_LOVR], rd_stat,
      (load_a && a_unread_ff) || (load_b && b_unread_ff));
    nxt_flags[`TCC_S_CPC] = upd_flag(flags_ff[`TCC_S_CPC], rd_stat, cmp_hit);
    nxt_flags[`TCC_S_LDA] = upd_flag(flags_ff[`TCC_S_LDA], rd_stat, load_a);
    nxt_flags[`TCC_S_LDB] = upd_flag(flags_ff[`TCC_S_LDB], rd_stat, load_b);
    nxt_flags[`TCC_S_ETRG] = upd_flag(flags_ff[`TCC_S_ETRG], rd_stat, ext_trig);
    nxt_flags[18:16] = (flags_ff[18:16] & {3{~rd_stat}}) |
      (pin_chg & {3{tmr_on}});
  end

  always @(posedge clk_sys) begin
    if (lrst) begin
      flags_ff <= 19'h00000;
      irq_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      irq_ff <= |(nxt_flags & imask_ff);
    end
  end

  // register read mux
  always @* begin
    nxt_rdata = 32'h00000000;
    case (addr)
      `TCC_A_PINLVL: nxt_rdata[18:16] = pin_lvl_ff;
      `TCC_A_ODSTAT: nxt_rdata[18:16] = od_ff;
      `TCC_A_CGSTAT: nxt_rdata[1:0] = cgate_ff;
      `TCC_A_MODE: nxt_rdata[19:0] = mode_ff;
      `TCC_A_STAT: begin
        nxt_rdata[18:0] = flags_ff;
        nxt_rdata[`TCC_S_CLKSTA] = clk_on_ff;
        nxt_rdata[`TCC_S_MIOA] = timer_io_a_in;
        nxt_rdata[`TCC_S_MIOB] = timer_io_b_in;
      end
      `TCC_A_IMASK: nxt_rdata[18:0] = imask_ff;
      `TCC_A_CNT: nxt_rdata[15:0] = cnt_ff;
      `TCC_A_CAPA: nxt_rdata[15:0] = cap_a_ff;
      `TCC_A_CAPB: nxt_rdata[15:0] = cap_b_ff;
      `TCC_A_CMPC: nxt_rdata[15:0] = cmp_c_ff;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_stb) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end
endmodule // tcc_channel
`default_nettype wire

// file: test/tcc_channel_monitor.sv
// Purpose: port checker for the timer capture channel
// Assumes: strobes one cycle long, read data the cycle after
// Notes: bound to every tcc_channel instance
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
module tcc_channel_monitor (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata_ff,
  input wire timer_io_a_in,
  input wire timer_io_a_oe_ff,
  input wire timer_io_b_in,
  input wire timer_io_b_oe_ff,
  input wire ext_count_clock_pin
);
  wire [2:0] pins = {ext_count_clock_pin, timer_io_a_in, timer_io_b_in};
  logic wave_ff;
  // expected waveform bit: last mode write, zero after either reset
  always @(posedge clk_sys) begin
    if (!rstn || (wr_stb && addr == `TCC_A_CTRL && wdata[`TCC_CTL_RST])) begin
      wave_ff <= 1'b0;
    end else if (wr_stb && addr == `TCC_A_MODE) begin
      wave_ff <= wdata[`TCC_M_WAVE];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  pins_input_a: assert property (
    !timer_io_a_oe_ff && !timer_io_b_oe_ff)
    else $error("io pin driven in capture mode");
  pin_level_a: assert property (
    (rd_stb && addr == `TCC_A_PINLVL && $stable(pins)) |=> rdata_ff[18:16] == $past(pins))
    else $error("pin level read wrong");
  gate_on_a: assert property (
    (wr_stb && addr == `TCC_A_CGEN) ##1 (rd_stb && addr == `TCC_A_CGSTAT)
    |=> (rdata_ff[1:0] & $past(wdata[1:0], 2)) == $past(wdata[1:0], 2))
    else $error("clock gate enable lost");
  gate_off_a: assert property (
    (wr_stb && addr == `TCC_A_CGDIS) ##1 (rd_stb && addr == `TCC_A_CGSTAT)
    |=> (rdata_ff[1:0] & $past(wdata[1:0], 2)) == 2'h0)
    else $error("clock gate disable lost");
  drain_set_a: assert property (
    (wr_stb && addr == `TCC_A_ODEN) ##1 (rd_stb && addr == `TCC_A_ODSTAT)
    |=> (rdata_ff[18:16] & $past(wdata[18:16], 2)) == $past(wdata[18:16], 2))
    else $error("open drain set lost");
  drain_clear_a: assert property (
    (wr_stb && addr == `TCC_A_ODDIS) ##1 (rd_stb && addr == `TCC_A_ODSTAT)
    |=> (rdata_ff[18:16] & $past(wdata[18:16], 2)) == 3'h0)
    else $error("open drain clear lost");
  mode_rw_a: assert property (
    (wr_stb && addr == `TCC_A_MODE) ##1 (rd_stb && addr == `TCC_A_MODE)
    |=> rdata_ff == ($past(wdata, 2) & 32'h000fc7ff))
    else $error("mode read back wrong");
  capture_mode_a: assert property (
    (rd_stb && addr == `TCC_A_MODE) |=> rdata_ff[`TCC_M_WAVE] == $past(wave_ff))
    else $error("waveform bit not as written or not cleared by reset");
  soft_reset_a: assert property (
    (wr_stb && addr == `TCC_A_CTRL && wdata[0]) ##1 (rd_stb && addr == `TCC_A_MODE)
    |=> rdata_ff == 32'h0)
    else $error("mode survived soft reset");
  read_idle_a: assert property (
    !rd_stb |=> rdata_ff == 32'h0)
    else $error("read data outside read cycle");
  write_only_a: assert property (
    (rd_stb && (addr == `TCC_A_CTRL || addr == 8'h68)) |=> rdata_ff == 32'h0)
    else $error("write only or unmapped read not zero");
endmodule // tcc_channel_monitor
bind tcc_channel tcc_channel_monitor i_mon (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
  .timer_io_a_in(timer_io_a_in), .timer_io_a_oe_ff(timer_io_a_oe_ff),
  .timer_io_b_in(timer_io_b_in), .timer_io_b_oe_ff(timer_io_b_oe_ff),
  .ext_count_clock_pin(ext_count_clock_pin));
`default_nettype wire

// file: test/tcc_pin_src.sv
// Purpose: signal sources on the channel's timer pins
// Assumes: bench asks for levels one cycle ahead
// Notes: bit 5 count clock pin, 4 io a, 3 io b, 2:0 external clocks
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_src (
  input wire logic clk_sys,
  input wire logic [5:0] want,
  output logic [5:0] pins
);
  initial pins = 6'h0;
  // move only after an edge, so the channel never samples mid-change
  always @(posedge clk_sys) begin
    pins <= want;
  end
endmodule // tcc_pin_src
`default_nettype wire

// file: test/tb.sv
// Purpose: self-checking bench for the timer capture channel
// Assumes: register port answers the cycle after a read strobe
// Notes: overflow needs 65536 ticks and is left out for run time
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic sync_trigger = 1'b0;
  logic [5:0] want = 6'h0;
  wire [5:0] src;
  wire [31:0] rdata_ff;
  wire irq_ff, a_out, a_oe, b_out, b_oe;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] d, e;
  int divs [5] = '{2, 8, 32, 128, 1024};
  logic [7:0] ga [5] = '{`TCC_A_CGEN, `TCC_A_CGDIS, `TCC_A_CGEN, `TCC_A_CGDIS, `TCC_A_CGEN};
  logic [31:0] gw [5] = '{32'h3, 32'h1, 32'h0, 32'h2, 32'h3};
  logic [31:0] ge [5] = '{32'h3, 32'h2, 32'h2, 32'h0, 32'h3};
  always #2.5 clk_sys = ~clk_sys;
  tcc_pin_src i_src (.clk_sys(clk_sys), .want(want), .pins(src));
  tcc_channel i_dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff), .irq_ff(irq_ff),
    .timer_io_a_in(a_oe ? a_out : src[4]), .timer_io_a_out_ff(a_out), .timer_io_a_oe_ff(a_oe),
    .timer_io_b_in(b_oe ? b_out : src[3]), .timer_io_b_out_ff(b_out), .timer_io_b_oe_ff(b_oe),
    .ext_count_clock_pin(src[5]), .external_clock(src[2:0]), .sync_trigger(sync_trigger));
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(posedge clk_sys);
    v = rdata_ff;
  endtask
  task automatic cyc(input int n);
    wr_stb <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  // counter advance between two reads exactly gap cycles apart
  task automatic rate(input int gap, output logic [31:0] n);
    logic [31:0] a0;
    logic [31:0] a1;
    rd(`TCC_A_CNT, a0);
    cyc(gap - 2);
    rd(`TCC_A_CNT, a1);
    n = a1 - a0;
  endtask
  // n full periods on the far-side pins, hi level then lo level
  task automatic pulse(input int n, input logic [5:0] hi, input logic [5:0] lo);
    repeat (n) begin
      want <= hi;
      cyc(3);
      want <= lo;
      cyc(3);
    end
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hdc2f86ce));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`TCC_A_CGSTAT, d);
    chk("gate reset", d, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(ga[i], gw[i]);
      rd(`TCC_A_CGSTAT, d);
      chk("clock gate", d, ge[i]);
    end
    for (int i = 0; i < 8; i++) begin
      want <= 6'($urandom);
      cyc(4);
      rd(`TCC_A_PINLVL, d);
      chk("pin level", d & 32'h70000, {13'h0, want[5:3], 16'h0});
    end
    e = 32'h0;
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(`TCC_A_ODEN, d);
      e = e | (d & 32'h70000);
      rd(`TCC_A_ODSTAT, d);
      chk("drain set", d & 32'h70000, e);
      d = $urandom;
      wr(`TCC_A_ODDIS, d);
      e = e & ~d;
      rd(`TCC_A_ODSTAT, d);
      chk("drain clear", d & 32'h70000, e);
    end
    for (int i = 0; i < 4; i++) begin
      e = $urandom | 32'h8000;
      wr(`TCC_A_MODE, e);
      rd(`TCC_A_MODE, d);
      chk("mode", d, e & 32'h000fc7ff);
    end
    $display("done registers");
    wr(`TCC_A_CTRL, 32'h2);
    for (int i = 0; i < 5; i++) begin
      wr(`TCC_A_MODE, i);
      wr(`TCC_A_CTRL, 32'h8);
      cyc(divs[i] + 4);
      rate(4 * divs[i], d);
      chk("count rate", d, 32'h4);
    end
    wr(`TCC_A_MODE, 32'h0);
    wr(`TCC_A_CTRL, 32'h6);
    rate(20, d);
    chk("clock off", d, 32'h0);
    wr(`TCC_A_CTRL, 32'h2);
    wr(`TCC_A_CTRL, 32'h8);
    cyc(4);
    rate(20, d);
    chk("clock on", d, 32'ha);
    wr(`TCC_A_CGDIS, 32'h2);
    rate(20, d);
    chk("channel gated", d, 32'h0);
    wr(`TCC_A_CGEN, 32'h2);
    wr(`TCC_A_CTRL, 32'h2);
    wr(`TCC_A_CTRL, 32'h8);
    cyc(100);
    sync_trigger <= 1'b1;
    @(posedge clk_sys);
    sync_trigger <= 1'b0;
    cyc(3);
    rd(`TCC_A_CNT, d);
    chk("sync restart", d & 32'hfff8, 32'h0);
    $display("done counter");
    // capture a on rising io a, interrupt on a load
    wr(`TCC_A_MODE, 32'h10000);
    wr(`TCC_A_IEN, 32'h20);
    want <= 6'h0;
    cyc(4);
    rd(`TCC_A_STAT, d);
    want <= 6'h10;
    cyc(4);
    chk("irq raised", {31'h0, irq_ff}, 32'h1);
    rd(`TCC_A_STAT, d);
    chk("a loaded", d & 32'h20063, 32'h20020);
    want <= 6'h0;
    cyc(4);
    want <= 6'h10;
    cyc(4);
    rd(`TCC_A_STAT, d);
    chk("overrun", d & 32'h20063, 32'h20022);
    rd(`TCC_A_STAT, d);
    chk("flags cleared", d & 32'h20063, 32'h0);
    cyc(2);
    chk("irq cleared", {31'h0, irq_ff}, 32'h0);
    e = 32'd10 + ($urandom % 20);
    wr(`TCC_A_CMPC, e);
    wr(`TCC_A_CTRL, 32'h8);
    cyc(4);
    rd(`TCC_A_STAT, d);
    cyc(2 * e - 16);
    rd(`TCC_A_STAT, d);
    chk("compare early", d & 32'h10, 32'h0);
    cyc(16);
    rd(`TCC_A_STAT, d);
    chk("compare hit", d & 32'h10, 32'h10);
    want <= 6'h0;
    for (int k = 0; k < 4; k++) begin
      wr(`TCC_A_MODE, 32'h400 | (k << 8));
      rd(`TCC_A_STAT, d);
      want <= 6'h10;
      cyc(4);
      rd(`TCC_A_STAT, d);
      chk("rise trigger", d & 32'h80, (k & 1) ? 32'h80 : 32'h0);
      want <= 6'h0;
      cyc(4);
      rd(`TCC_A_STAT, d);
      chk("fall trigger", d & 32'h80, (k & 2) ? 32'h80 : 32'h0);
    end
    rd(`TCC_A_CNT, d);
    chk("trigger restart", d & 32'hfff8, 32'h0);
    // external clock 0: first rising edge restarts, later ones count
    e = 32'd1 + ($urandom % 8);
    wr(`TCC_A_MODE, 32'h5);
    wr(`TCC_A_CTRL, 32'h8);
    pulse(e + 1, 6'h1, 6'h0);
    rd(`TCC_A_CNT, d);
    chk("external count", d, e);
    wr(`TCC_A_MODE, 32'h25);
    pulse(3, 6'h1, 6'h0);
    rd(`TCC_A_CNT, d);
    chk("burst low", d, e);
    pulse(3, 6'h3, 6'h2);
    rd(`TCC_A_CNT, d);
    chk("burst high", d, e + 32'd3);
    wr(`TCC_A_MODE, 32'h2d);
    pulse(2, 6'h3, 6'h2);
    rd(`TCC_A_CNT, d);
    chk("inverted clock", d, e + 32'd5);
    // rising io a loads capture b, then stops counter or also its clock
    for (int k = 0; k < 2; k++) begin
      wr(`TCC_A_MODE, 32'h40000 | (32'h40 << k));
      wr(`TCC_A_CTRL, 32'h2);
      wr(`TCC_A_CTRL, 32'h8);
      cyc(4);
      rd(`TCC_A_STAT, d);
      want <= 6'h10;
      cyc(4);
      rd(`TCC_A_STAT, d);
      chk("b load", d & 32'h140, k ? 32'h40 : 32'h140);
      rate(20, d);
      chk("stop on b", d, 32'h0);
      want <= 6'h0;
      cyc(4);
    end
    chk("io not driven", {28'h0, a_out, a_oe, b_out, b_oe}, 32'h0);
    $display("done capture");
    wr(`TCC_A_ODEN, 32'h70000);
    wr(`TCC_A_MODE, 32'h4);
    wr(`TCC_A_CTRL, 32'h1);
    rd(`TCC_A_MODE, d);
    chk("reset mode", d, 32'h0);
    rd(`TCC_A_ODSTAT, d);
    chk("reset drain", d, 32'h0);
    rd(`TCC_A_CGSTAT, d);
    chk("gate kept", d, 32'h3);
    rd(`TCC_A_CTRL, d);
    chk("write only", d, 32'h0);
    rd(8'h68, d);
    chk("unmapped", d, 32'h0);
    $display("done soft reset");
    end_sim();
  end
endmodule // tb
`default_nettype wire
